// *** design/sid_pkg.sv ***
package sid_pkg;

	// Register byte offsets on the Wishbone slave.
	localparam logic [4:0] OFS_DW2_LO = 5'h00;
	localparam logic [4:0] OFS_DW1_HI = 5'h04;
	localparam logic [4:0] OFS_DW3_HI = 5'h08;
	localparam logic [4:0] OFS_CTRL   = 5'h0c;
	localparam logic [4:0] OFS_STAT   = 5'h10;

	// Field positions inside the 32-bit descriptor words.
	localparam int RETRY_LSB = 23;
	localparam int RETRY_W   = 2;
	localparam int BYTES_LSB = 0;
	localparam int BYTES_W   = 12;
	localparam int HUB_LSB   = 25;
	localparam int PORT_LSB  = 18;
	localparam int ADDR7_W   = 7;
	localparam int SPEED_LSB = 16;
	localparam int SPLIT_BIT = 14;
	localparam int TYPE_LSB  = 12;
	localparam int TOKEN_LSB = 10;
	localparam int BUF_LSB   = 8;
	localparam int BUF_W     = 16;
	localparam int SCHED_LSB = 0;
	localparam int SCHED_W   = 8;
	localparam int FRAME_W   = 11;

	// Control and status bits.
	localparam int CTRL_GO_BIT  = 0;
	localparam int STAT_ACT_BIT = 0;
	localparam int STAT_XERR    = 1;
	localparam int STAT_CFGERR  = 2;
	localparam int STAT_DONE    = 3;

	// Field encodings.
	localparam logic [1:0] TYPE_INTR  = 2'h3;
	localparam logic [1:0] TOKEN_OUT  = 2'h0;
	localparam logic [1:0] TOKEN_IN   = 2'h1;
	localparam logic [1:0] SPEED_LOW  = 2'h2;
	localparam logic [1:0] SPEED_FULL = 2'h0;
	localparam logic [1:0] RETRY_NONE = 2'h0;
	localparam logic [6:0] HUB_EMBED  = 7'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic {
		PID_OUT = 1'b0,
		PID_IN  = 1'b1
	} sid_pid_t;

	typedef struct packed {
		sid_pid_t    pid;
		logic [6:0]  hubAddr;
		logic        embeddedHub;
		logic [6:0]  ttPortIndex;
		logic        lowSpeed;
		logic        split;
		logic [15:0] payloadBufferStart;
	} sid_token_t;

endpackage

// *** design/sid_sched.sv ***
`timescale 1ns/100ps
module sid_sched (
	input  wire logic [sid_pkg::SCHED_W-1:0] schedule,
	input  wire logic [sid_pkg::FRAME_W-1:0] frameNum,
	output logic                             due
);
	import sid_pkg::*;

	// Position of the highest set bit of the five-bit frame pattern.
	function automatic logic [2:0] msbIndex(input logic [4:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 0; i < 5; i++) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	wire logic [4:0] pattern = schedule[7:3];
	wire logic [2:0] topBit  = msbIndex(pattern);
	// Rate is twice the weight of the top bit, at most 32 frames.
	wire logic [5:0] rateMask = 6'((6'h2 << topBit) - 6'h1);
	wire logic       everyMs  = (pattern == 5'h00);
	wire logic       phaseHit = ((frameNum[5:0] & rateMask) == ({1'b0, pattern} & rateMask));

	assign due = everyMs | phaseHit;

endmodule // sid_sched

// *** design/sid_retry.sv ***
`timescale 1ns/100ps
module sid_retry (
	input  wire logic [sid_pkg::RETRY_W-1:0] budget,
	output logic [sid_pkg::RETRY_W-1:0]      nextBudget,
	output logic                             giveUp
);
	import sid_pkg::*;

	// A zero budget means one try only; otherwise count down to zero.
	assign giveUp     = (budget == RETRY_NONE) || (budget == 2'h1);
	assign nextBudget = (budget == RETRY_NONE) ? RETRY_NONE : 2'(budget - 2'h1);

endmodule // sid_retry

// *** design/sid_descriptor.sv ***
// Functional notes
// - Two-bit retry budget; zero means one try, else decrement per failure.
// - After the last allowed failed try the transaction-error flag is set.
// - Retry budget behaves like the queue-head error counter.
// - Hardware writes the bytes moved on a successful try into the twelve-bit byte count field.
// - Payload moves at the sixteen-bit buffer start address software gives.
// - Polling interval derives from the schedule byte; zero pattern runs every millisecond.
// - Schedule bits 7 to 3 match the frame number; rates up to 32 ms.
// - Split tokens target the seven-bit hub address; zero is the embedded hub.
// - Split tokens carry the seven-bit hub port index.
// - Speed field 10 means low-speed, 00 full-speed, only for splits.
`timescale 1ns/100ps
module sid_descriptor (
	input  wire logic                         clock,
	input  wire logic                         reset_n,
	input  wire logic                         wbCyc,
	input  wire logic                         wbStb,
	input  wire logic                         wbWe,
	input  wire logic [4:0]                   wbAdr,
	input  wire logic [3:0]                   wbSel,
	input  wire logic [31:0]                  wbDatI,
	output logic [31:0]                       wbDatO,
	output logic                              wbAck,
	input  wire logic                         frameTick,
	input  wire logic [sid_pkg::FRAME_W-1:0]  frameNum,
	output logic                              tokValid,
	input  wire logic                         tokReady,
	output sid_pkg::sid_token_t               token,
	input  wire logic                         tryDone,
	input  wire logic                         tryOk,
	input  wire logic [sid_pkg::BYTES_W-1:0]  tryBytes,
	output logic                              busy
);
	import sid_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WAIT   = 2'b01,
		ST_ISSUE  = 2'b10,
		ST_RESULT = 2'b11
	} sid_state_t;

	// Byte-lane merge for Wishbone writes.
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	sid_state_t  state_q, state_d;
	logic [31:0] dw2Lo_q, dw2Lo_d;
	logic [31:0] dw1Hi_q, dw1Hi_d;
	logic [31:0] dw3Hi_q, dw3Hi_d;
	logic        xErr_q, xErr_d;
	logic        cfgErr_q, cfgErr_d;
	logic        done_q, done_d;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        tokValid_q, tokValid_d;
	sid_token_t  token_q, token_d;
	logic        busy_q;

	// Bus decode.
	wire logic access   = wbCyc & wbStb & ~ack_q;
	wire logic wrAccess = access & wbWe;
	wire logic hitDw2   = (wbAdr == OFS_DW2_LO);
	wire logic hitDw1   = (wbAdr == OFS_DW1_HI);
	wire logic hitDw3   = (wbAdr == OFS_DW3_HI);
	wire logic hitCtrl  = (wbAdr == OFS_CTRL);
	wire logic hitStat  = (wbAdr == OFS_STAT);
	wire logic idle     = (state_q == ST_IDLE);
	wire logic descWrOk = wrAccess & idle;
	wire logic goWrite  = wrAccess & hitCtrl & wbSel[0] & wbDatI[CTRL_GO_BIT] & idle;
	wire logic statClr  = wrAccess & hitStat & wbSel[0];

	// Descriptor fields.
	wire logic [1:0]  retryBudget = dw3Hi_q[RETRY_LSB +: RETRY_W];
	wire logic [15:0] bufStart    = dw2Lo_q[BUF_LSB +: BUF_W];
	wire logic [7:0]  schedule    = dw2Lo_q[SCHED_LSB +: SCHED_W];
	wire logic [6:0]  hubAddr     = dw1Hi_q[HUB_LSB +: ADDR7_W];
	wire logic [6:0]  portIdx     = dw1Hi_q[PORT_LSB +: ADDR7_W];
	wire logic [1:0]  speedSelect = dw1Hi_q[SPEED_LSB +: 2];
	wire logic        splitSel    = dw1Hi_q[SPLIT_BIT];
	wire logic [1:0]  transferType = dw1Hi_q[TYPE_LSB +: 2];
	wire logic [1:0]  tokenCode   = dw1Hi_q[TOKEN_LSB +: 2];

	// Only interrupt transfers with OUT or IN tokens are served.
	wire logic typeOk  = (transferType == TYPE_INTR);
	wire logic tokOk   = (tokenCode == TOKEN_OUT) || (tokenCode == TOKEN_IN);
	wire logic speedOk = ~splitSel || (speedSelect == SPEED_LOW) || (speedSelect == SPEED_FULL);
	wire logic cfgOk   = typeOk & tokOk & speedOk;

	wire logic       due;
	wire logic [1:0] nextBudget;
	wire logic       giveUp;

	sid_sched u_sched (
		.schedule (schedule),
		.frameNum (frameNum),
		.due      (due)
	);

	sid_retry u_retry (
		.budget     (retryBudget),
		.nextBudget (nextBudget),
		.giveUp     (giveUp)
	);

	wire logic launch = (state_q == ST_WAIT) & frameTick & due;
	wire logic result = (state_q == ST_RESULT) & tryDone;
	wire logic okEnd  = result & tryOk;
	wire logic failEnd = result & ~tryOk & giveUp;
	wire logic failRetry = result & ~tryOk & ~giveUp;

	// Token assembled from the descriptor at launch.
	sid_token_t tokNew;
	assign tokNew.pid                = (tokenCode == TOKEN_IN) ? PID_IN : PID_OUT;
	assign tokNew.hubAddr            = hubAddr;
	assign tokNew.embeddedHub        = (hubAddr == HUB_EMBED);
	assign tokNew.ttPortIndex        = portIdx;
	assign tokNew.lowSpeed           = splitSel & (speedSelect == SPEED_LOW);
	assign tokNew.split              = splitSel;
	assign tokNew.payloadBufferStart = bufStart;

	// Next state.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (goWrite && cfgOk) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (launch) begin
					state_d = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (tokReady) begin
					state_d = ST_RESULT;
				end
			end
			ST_RESULT: begin
				if (okEnd || failEnd) begin
					state_d = ST_IDLE;
				end else if (failRetry) begin
					state_d = ST_WAIT;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Descriptor words; writes are refused while the transfer is active.
	assign dw2Lo_d = (descWrOk && hitDw2) ? laneMerge(dw2Lo_q, wbDatI, wbSel) : dw2Lo_q;
	assign dw1Hi_d = (descWrOk && hitDw1) ? laneMerge(dw1Hi_q, wbDatI, wbSel) : dw1Hi_q;

	always_comb begin
		dw3Hi_d = (descWrOk && hitDw3) ? laneMerge(dw3Hi_q, wbDatI, wbSel) : dw3Hi_q;
		if (okEnd) begin
			dw3Hi_d[BYTES_LSB +: BYTES_W] = tryBytes;
		end
		if (result && !tryOk) begin
			dw3Hi_d[RETRY_LSB +: RETRY_W] = nextBudget;
		end
	end

	// Flags: a hardware set wins over a software clear in the same cycle.
	wire logic clrX   = goWrite | (statClr & wbDatI[STAT_XERR]);
	wire logic clrCfg = goWrite | (statClr & wbDatI[STAT_CFGERR]);
	wire logic clrDn  = goWrite | (statClr & wbDatI[STAT_DONE]);
	wire logic setCfg = goWrite & ~cfgOk;
	assign xErr_d   = (xErr_q & ~clrX) | failEnd;
	assign cfgErr_d = (cfgErr_q & ~clrCfg) | setCfg;
	assign done_d   = (done_q & ~clrDn) | okEnd | failEnd | setCfg;

	assign tokValid_d = launch | (tokValid_q & ~tokReady);
	assign token_d    = launch ? tokNew : token_q;

	// Read data.
	wire logic [31:0] statWord = {28'h000_0000, done_q, cfgErr_q, xErr_q, ~idle};
	wire logic [31:0] rdMux = hitDw2  ? dw2Lo_q :
		hitDw1  ? dw1Hi_q :
		hitDw3  ? dw3Hi_q :
		hitStat ? statWord : WORD_ZERO;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			dw2Lo_q <= WORD_ZERO;
			dw1Hi_q <= WORD_ZERO;
			dw3Hi_q <= WORD_ZERO;
		end else begin
			state_q <= state_d;
			dw2Lo_q <= dw2Lo_d;
			dw1Hi_q <= dw1Hi_d;
			dw3Hi_q <= dw3Hi_d;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			xErr_q   <= 1'b0;
			cfgErr_q <= 1'b0;
			done_q   <= 1'b0;
			busy_q   <= 1'b0;
		end else begin
			xErr_q   <= xErr_d;
			cfgErr_q <= cfgErr_d;
			done_q   <= done_d;
			busy_q   <= (state_d != ST_IDLE);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_q      <= 1'b0;
			rdat_q     <= WORD_ZERO;
			tokValid_q <= 1'b0;
			token_q    <= '0;
		end else begin
			ack_q      <= access;
			rdat_q     <= access ? rdMux : WORD_ZERO;
			tokValid_q <= tokValid_d;
			token_q    <= token_d;
		end
	end

	assign wbAck    = ack_q;
	assign wbDatO   = rdat_q;
	assign tokValid = tokValid_q;
	assign token    = token_q;
	assign busy     = busy_q;

	// Waiting frames without a launch; the slowest rate allows 31 of them in a row.
	localparam logic [5:0] WAIT_LIMIT = 6'h20;
	logic [5:0]      waitFrames_q;
	wire logic       waitMiss     = (state_q == ST_WAIT) & frameTick & ~due;
	wire logic [5:0] waitFrames_d = (state_q != ST_WAIT) ? 6'h00 :
		waitMiss ? 6'(waitFrames_q + 6'h01) : waitFrames_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			waitFrames_q <= 6'h00;
		end else begin
			waitFrames_q <= waitFrames_d;
		end
	end

	// Checks.
	a_ack_once: assert property (@(posedge clock) disable iff (!reset_n)
		ack_q |=> !ack_q)
		else $error("Bus acknowledge held for two cycles.");
	a_launch_token: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> tokValid_q && state_q == ST_ISSUE)
		else $error("Due frame did not raise the token request.");
	a_pid_code: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> token_q.pid == (($past(tokenCode) == TOKEN_IN) ? PID_IN : PID_OUT))
		else $error("Token PID does not follow the token code.");
	a_hub_target: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> token_q.hubAddr == $past(hubAddr)
			&& token_q.embeddedHub == ($past(hubAddr) == HUB_EMBED))
		else $error("Hub address or embedded hub flag wrong.");
	a_port_index: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> token_q.ttPortIndex == $past(portIdx))
		else $error("Port index not carried into token.");
	a_speed_low: assert property (@(posedge clock) disable iff (!reset_n)
		tokValid_q && token_q.lowSpeed |-> token_q.split)
		else $error("Low speed flagged on a direct transaction.");
	a_bytes_done: assert property (@(posedge clock) disable iff (!reset_n)
		okEnd |=> dw3Hi_q[BYTES_LSB +: BYTES_W] == $past(tryBytes) && done_q && idle)
		else $error("Byte count not written on success.");
	a_retry_down: assert property (@(posedge clock) disable iff (!reset_n)
		failRetry |=> retryBudget == 2'($past(retryBudget) - 2'h1) && state_q == ST_WAIT)
		else $error("Retry budget not decremented.");
	a_xerr_set: assert property (@(posedge clock) disable iff (!reset_n)
		result && !tryOk && (retryBudget == RETRY_NONE || retryBudget == 2'h1)
		|=> xErr_q && idle)
		else $error("Transaction error not set when tries ran out.");
	a_cfg_refuse: assert property (@(posedge clock) disable iff (!reset_n)
		goWrite && !cfgOk |=> cfgErr_q && idle)
		else $error("Bad descriptor was not refused.");
	a_bufstart_out: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> token_q.payloadBufferStart == $past(bufStart))
		else $error("Buffer start not carried into token.");
	a_ack_answer: assert property (@(posedge clock) disable iff (!reset_n)
		access |=> ack_q)
		else $error("Bus request was not acknowledged in the next cycle.");
	a_rdat_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		!ack_q |-> rdat_q == WORD_ZERO)
		else $error("Read data not zero outside the acknowledge cycle.");
	a_tok_hold: assert property (@(posedge clock) disable iff (!reset_n)
		tokValid_q && !tokReady |=> tokValid_q && $stable(token_q))
		else $error("Token changed or dropped before it was accepted.");
	a_tok_drop: assert property (@(posedge clock) disable iff (!reset_n)
		tokValid_q && tokReady |=> !tokValid_q)
		else $error("Token request stayed up after acceptance.");
	a_split_select: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> token_q.split == $past(splitSel))
		else $error("Split flag does not follow split select.");
	a_low_speed: assert property (@(posedge clock) disable iff (!reset_n)
		launch |=> token_q.lowSpeed == ($past(splitSel) && $past(speedSelect) == SPEED_LOW))
		else $error("Low speed flag does not follow the speed field.");
	a_desc_locked: assert property (@(posedge clock) disable iff (!reset_n)
		wrAccess && !idle |=> dw2Lo_q == $past(dw2Lo_q) && dw1Hi_q == $past(dw1Hi_q))
		else $error("Descriptor word changed while the transfer was active.");
	a_budget_kept: assert property (@(posedge clock) disable iff (!reset_n)
		okEnd |=> retryBudget == $past(retryBudget))
		else $error("Retry budget changed on a successful try.");
	a_every_frame: assert property (@(posedge clock) disable iff (!reset_n)
		state_q == ST_WAIT && frameTick && schedule[7:3] == 5'h00 |=> state_q == ST_ISSUE)
		else $error("Every-frame schedule did not launch.");
	a_wait_miss: assert property (@(posedge clock) disable iff (!reset_n)
		state_q == ST_WAIT && frameTick && !due |=> state_q == ST_WAIT && !tokValid_q)
		else $error("Transfer launched in a frame that is not due.");
	a_rate_bound: assert property (@(posedge clock) disable iff (!reset_n)
		waitFrames_q < WAIT_LIMIT)
		else $error("Waited longer than the slowest polling rate.");
	a_go_arms: assert property (@(posedge clock) disable iff (!reset_n)
		goWrite && cfgOk |=> busy_q && state_q == ST_WAIT)
		else $error("Valid descriptor was not armed.");
	a_xerr_clear: assert property (@(posedge clock) disable iff (!reset_n)
		statClr && wbDatI[STAT_XERR] && !failEnd |=> !xErr_q)
		else $error("Transaction error flag not cleared by software.");

	c_success: cover property (@(posedge clock) disable iff (!reset_n) okEnd);
	c_exhaust: cover property (@(posedge clock) disable iff (!reset_n) failEnd);
	c_retry: cover property (@(posedge clock) disable iff (!reset_n) failRetry);
	c_split_low: cover property (@(posedge clock) disable iff (!reset_n)
		launch && tokNew.lowSpeed);
	c_refused: cover property (@(posedge clock) disable iff (!reset_n) goWrite && !cfgOk);

endmodule // sid_descriptor

// *** verification/sid_engine_model.sv ***
`timescale 1ns/100ps
module sid_engine_model (
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	input  wire logic                        tokValid,
	input  wire sid_pkg::sid_token_t         token,
	output logic                             tokReady,
	output logic                             tryDone,
	output logic                             tryOk,
	output logic [sid_pkg::BYTES_W-1:0]      tryBytes,
	input  wire logic                        okMode,
	input  wire logic [sid_pkg::BYTES_W-1:0] bytesIn,
	input  wire logic [1:0]                  stall,
	output int                               tokCount,
	output sid_pkg::sid_token_t              lastTok
);
	import sid_pkg::*;
	logic [1:0] waitQ;
	logic       pendingQ;
	// Accepts a token after a programmable stall and reports one outcome per try.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tokReady <= 1'b0;
			tryDone  <= 1'b0;
			tryOk    <= 1'b0;
			tryBytes <= '0;
			tokCount <= 0;
			lastTok  <= '0;
			waitQ    <= 2'h0;
			pendingQ <= 1'b0;
		end else begin
			tokReady <= 1'b0;
			tryDone  <= pendingQ;
			tryOk    <= pendingQ ? okMode : ~tryOk;
			tryBytes <= pendingQ ? bytesIn : ~tryBytes;
			pendingQ <= tokValid && tokReady;
			if (tokValid && !tokReady && !pendingQ) begin
				waitQ    <= (waitQ == stall) ? 2'h0 : waitQ + 2'h1;
				tokReady <= (waitQ == stall);
			end
			if (tokValid && tokReady) begin
				lastTok  <= token;
				tokCount <= tokCount + 1;
			end
		end
	end
endmodule // sid_engine_model

// *** verification/tb_split_interrupt_descriptor.sv ***
`timescale 1ns/100ps
module tb_split_interrupt_descriptor;
	import sid_pkg::*;
	logic                clock = 1'b0, reset_n = 1'b0;
	logic                wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [4:0]          wbAdr = 5'h00;
	logic [3:0]          wbSel = 4'hf;
	logic [31:0]         wbDatI = 32'h0, wbDatO, rs = 32'h269e;
	logic                frameTick = 1'b0, tokValid, tokReady, tryDone, tryOk, busy;
	logic [FRAME_W-1:0]  frameNum = '0;
	logic [BYTES_W-1:0]  tryBytes, bytesIn = '0;
	logic                okMode = 1'b0;
	logic [1:0]          stall = 2'h0;
	sid_token_t          token, lastTok;
	int                  tokCount, err_count = 0, check_count = 0, fn = 0;
	int                  pTab[10] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 31};
	logic [31:0]         bad[3] = '{32'h0000_1000, 32'h0000_3800, 32'h0001_7000};

	sid_descriptor sid_descriptor_inst (.clock(clock), .reset_n(reset_n), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
		.wbDatO(wbDatO), .wbAck(wbAck), .frameTick(frameTick), .frameNum(frameNum),
		.tokValid(tokValid), .tokReady(tokReady), .token(token), .tryDone(tryDone),
		.tryOk(tryOk), .tryBytes(tryBytes), .busy(busy));
	sid_engine_model sid_engine_model_inst (.clock(clock), .reset_n(reset_n),
		.tokValid(tokValid), .token(token), .tokReady(tokReady), .tryDone(tryDone),
		.tryOk(tryOk), .tryBytes(tryBytes), .okMode(okMode), .bytesIn(bytesIn),
		.stall(stall), .tokCount(tokCount), .lastTok(lastTok));

	always #10 clock = ~clock;

	function logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			finish_test();
		end
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic frames(input int n);
		repeat (n) begin
			@(posedge clock);
			frameTick <= 1'b1;
			frameNum <= FRAME_W'(fn);
			@(posedge clock);
			frameTick <= 1'b0;
			fn++;
			repeat (10) @(posedge clock);
		end
	endtask

	task automatic run(input int bud, input int p, input logic ok, input logic hub0);
		logic [31:0] q, r, w1, w2;
		int          rem, tries, rate, h, k, base;
		logic        act, xe, spl;
		logic [6:0]  hub;
		logic [1:0]  spd;
		sid_token_t  e;
		r = rnd();
		q = rnd();
		hub = hub0 ? 7'h00 : r[6:0];
		spl = r[14];
		spd = spl ? {r[16], 1'b0} : r[17:16];
		w1 = {hub, r[13:7], spd, 1'b0, spl, TYPE_INTR, 1'b0, r[15], 10'h0};
		w2 = {8'h00, r[31:16], 5'(p), q[2:0]};
		stall <= q[9:8];
		okMode <= ok;
		bytesIn <= q[27:16];
		wb(1'b1, OFS_DW2_LO, w2, q);
		wb(1'b1, OFS_DW1_HI, w1, q);
		wb(1'b1, OFS_DW3_HI, 32'(bud) << 23, q);
		wb(1'b1, OFS_CTRL, 32'h1, q);
		wb(1'b1, OFS_DW2_LO, ~w2, q);
		wb(1'b0, OFS_DW2_LO, 32'h0, q);
		chk(q, w2);
		base = tokCount;
		rem = bud;
		act = 1'b1;
		xe = 1'b0;
		tries = 0;
		h = 1;
		while (2 * h <= p) h = 2 * h;
		rate = (p == 0) ? 1 : 2 * h;
		for (k = 0; k < 4 * rate + 1; k++) begin
			if (act && (fn % rate) == (p % rate)) begin
				tries++;
				if (ok) act = 1'b0;
				else if (rem <= 1) begin
					act = 1'b0;
					xe = 1'b1;
					rem = 0;
				end else rem--;
			end
			frames(1);
		end
		chk(tokCount - base, tries);
		chk(busy, 1'b0);
		wb(1'b0, OFS_STAT, 32'h0, q);
		chk(q, {28'h0, 1'b1, 1'b0, xe, 1'b0});
		wb(1'b0, OFS_DW3_HI, 32'h0, q);
		chk(q & (ok ? 32'hffff_ffff : 32'h0180_0000),
			{7'h0, 2'(rem), 11'h0, ok ? bytesIn : 12'h0});
		e = {r[15] ? PID_IN : PID_OUT, hub, hub == HUB_EMBED, r[13:7],
			spl && spd == SPEED_LOW, spl, r[31:16]};
		chk(lastTok, e);
	endtask

	initial begin
		logic [31:0] q;
		int          i, base;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		for (i = 0; i < 6; i++) begin
			wb(1'b0, 5'(i * 4), 32'h0, q);
			chk(q, 32'h0);
		end
		$display("reset values test done");
		for (i = 0; i < 10; i++) run(i % 4, pTab[i], (i % 3) == 0, i == 1);
		$display("schedule and retry test done");
		base = tokCount;
		for (i = 0; i < 3; i++) begin
			wb(1'b1, OFS_DW1_HI, bad[i], q);
			wb(1'b1, OFS_CTRL, 32'h1, q);
			wb(1'b0, OFS_STAT, 32'h0, q);
			chk(q, 32'hc);
		end
		frames(2);
		chk(tokCount - base, 0);
		wb(1'b1, OFS_STAT, 32'he, q);
		wb(1'b0, OFS_STAT, 32'h0, q);
		chk(q, 32'h0);
		$display("config refusal test done");
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge clock);
		err_count++;
		finish_test();
	end
endmodule // tb_split_interrupt_descriptor
